// File: rtl/cpust_regs.sv
// processor architectural state: registers, supervision state, save registers
`timescale 1ns/1ps
`include "cpust_cfg.svh"

module cpust_regs (
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic [4:0]          rdAddrA,
  input  wire logic [4:0]          rdAddrB,
  input  wire logic                gprWe,
  input  wire logic [4:0]          gprWaddr,
  input  wire logic [31:0]         gprWdata,
  input  wire cpust_pkg::cpust_spr_t spr,
  input  wire cpust_pkg::cpust_exc_t exc,
  input  wire cpust_pkg::cpust_alu_t alu,
  input  wire logic                fpDone,
  input  wire logic [8:0]          fpFlags,
  input  wire logic                tickReq,
  input  wire logic                extIrqReq,
  output logic [31:0]              rdDataA,
  output logic [31:0]              rdDataB,
  output logic [31:0]              sprRdata,
  output logic                     sprErr,
  output logic                     rangeExc,
  output logic                     tickExc,
  output logic                     extIrqExc,
  output logic [31:0]              supervisionState,
  output logic                     supervisorMode,
  output logic                     dataCacheEn,
  output logic                     instrCacheEn,
  output logic                     dataMmuEn,
  output logic                     instrMmuEn,
  output logic                     littleEndian,
  output logic                     branchFlag,
  output logic                     carryFlag,
  output logic [31:0]              vectorBase,
  output logic [3:0]               contextIndex,
  output logic                     fpTrapEn,
  output cpust_pkg::cpust_round_t  fpRoundSel,
  output logic [31:0]              fpControlStatus
);

  cpust_pkg::cpust_state_t q;         // registered state
  cpust_pkg::cpust_state_t d;         // next state
  cpust_pkg::cpust_state_t resetVal;  // state after reset
  logic [3:0]              actSet;    // active register set
  logic [3:0]              saveIdx;   // save slot on exception
  logic                    sup;       // supervisor mode now
  logic [3:0]              sprSet;    // set field of mapped gpr index
  logic [4:0]              sprReg;    // register field of mapped gpr index
  logic [3:0]              sprSlot;   // save slot of mapped index

  // reset image: everything zero but supervision state
  always_comb begin
    resetVal       = '0;
    resetVal.sr    = `CPUST_SR_RESET;
    resetVal.fp_control_status = `CPUST_FP_RESET;
  end

  // next-state logic
  always_comb begin
    d          = q;
    d.sprErr   = 1'b0;
    d.sprRdata = 32'h0000_0000;
    d.rangeExc = 1'b0;
    sup        = q.sr[`CPUST_SR_SM];
    sprSet     = spr.addr[8:5];
    sprReg     = spr.addr[4:0];
    sprSlot    = spr.addr[3:0];
    // shadow sets only while auto switch is on
    actSet     = q.sr[`CPUST_SR_CE] ? q.sr[`CPUST_SR_CID] : 4'h0;
    saveIdx    = q.sr[`CPUST_SR_CE] ? q.sr[`CPUST_SR_CID] + 4'h1 : 4'h0;

    // operand reads, register zero reads zero
    d.rdA = (rdAddrA == 5'h00) ? 32'h0000_0000 : q.general_register[actSet][rdAddrA];
    d.rdB = (rdAddrB == 5'h00) ? 32'h0000_0000 : q.general_register[actSet][rdAddrB];

    // destination write, register zero never stored
    if (gprWe && gprWaddr != 5'h00) begin
      d.general_register[actSet][gprWaddr] = gprWdata;
    end

    // special-register moves
    if (spr.we || spr.re) begin
      if (spr.addr == `CPUST_IDX_SR) begin
        // supervisor only; reserved bits zero, fixed one kept
        if (!sup) begin
          d.sprErr = 1'b1;
        end else begin
          if (spr.we) begin
            d.sr = (spr.wdata & `CPUST_SR_WMASK) | `CPUST_SR_ONE;
          end
          if (spr.re) begin
            d.sprRdata = q.sr;
          end
        end
      end else if (spr.addr == `CPUST_IDX_FP_CONTROL_STATUS) begin
        // user may only read, and only when permitted
        if (spr.we && !sup) begin
          d.sprErr = 1'b1;
        end else if (spr.we) begin
          d.fp_control_status = spr.wdata & `CPUST_FP_WMASK;
        end
        if (spr.re && (sup || q.sr[`CPUST_SR_USER_SPR_READ_ENABLE])) begin
          d.sprRdata = q.fp_control_status;
        end else if (spr.re) begin
          d.sprErr = 1'b1;
        end
      end else if (spr.addr[15:4] == `CPUST_IDX_EPC >> 4) begin
        // return pc slots
        if (!sup) begin
          d.sprErr = 1'b1;
        end else begin
          if (spr.we) begin
            d.epc[sprSlot] = spr.wdata;
          end
          if (spr.re) begin
            d.sprRdata = q.epc[sprSlot];
          end
        end
      end else if (spr.addr[15:4] == `CPUST_IDX_EXCEPTION_FAULT_ADDRESS >> 4) begin
        // fault address slots
        if (!sup) begin
          d.sprErr = 1'b1;
        end else begin
          if (spr.we) begin
            d.exception_fault_address[sprSlot] = spr.wdata;
          end
          if (spr.re) begin
            d.sprRdata = q.exception_fault_address[sprSlot];
          end
        end
      end else if (spr.addr[15:4] == `CPUST_IDX_ESR >> 4) begin
        // saved state slots
        if (!sup) begin
          d.sprErr = 1'b1;
        end else begin
          if (spr.we) begin
            d.exception_saved_state[sprSlot] = spr.wdata;
          end
          if (spr.re) begin
            d.sprRdata = q.exception_saved_state[sprSlot];
          end
        end
      end else if (spr.addr[15:9] == `CPUST_IDX_GPR >> 9) begin
        // general registers of every set, for a debugger
        if (!sup) begin
          d.sprErr = 1'b1;
        end else begin
          if (spr.we && sprReg != 5'h00) begin
            d.general_register[sprSet][sprReg] = spr.wdata;
          end
          if (spr.re && sprReg != 5'h00) begin
            d.sprRdata = q.general_register[sprSet][sprReg];
          end
        end
      end
      // any other index reads zero and is ignored
    end

    // arithmetic flags; pipeline update overrides a same-cycle move
    if (alu.aluWe) begin
      d.sr[`CPUST_SR_CY] = alu.carry;
      d.sr[`CPUST_SR_OV] = alu.overflow;
      d.rangeExc = alu.overflow & q.sr[`CPUST_SR_OVE];
    end
    if (alu.cmpWe) begin
      d.sr[`CPUST_SR_F] = alu.cmpFlag;
    end

    // fp status: new flags are or-ed after a clearing write
    if (fpDone) begin
      d.fp_control_status[`CPUST_FP_FLAGS] = d.fp_control_status[`CPUST_FP_FLAGS] | fpFlags;
    end

    // event recognition gated by the enables
    d.tickExc = tickReq & q.sr[`CPUST_SR_TEE];
    d.extExc  = extIrqReq & q.sr[`CPUST_SR_IEE];

    // exception entry has the last word
    if (exc.take) begin
      d.epc[saveIdx]  = exc.pc;
      d.exception_fault_address[saveIdx] = exc.ea;
      d.exception_saved_state[saveIdx]  = q.sr;
      d.sr[`CPUST_SR_SM]  = 1'b1;
      d.sr[`CPUST_SR_TEE] = 1'b0;
      d.sr[`CPUST_SR_IEE] = 1'b0;
      d.sr[`CPUST_SR_DSX] = exc.delaySlot;
      if (q.sr[`CPUST_SR_CE]) begin
        d.sr[`CPUST_SR_CID] = saveIdx;
      end
    end
    d.sr[`CPUST_SR_FO] = 1'b1;
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= resetVal;
    end else begin
      q <= d;
    end
  end

  // outputs wired from state flops
  assign rdDataA          = q.rdA;
  assign rdDataB          = q.rdB;
  assign sprRdata         = q.sprRdata;
  assign sprErr           = q.sprErr;
  assign rangeExc         = q.rangeExc;
  assign tickExc          = q.tickExc;
  assign extIrqExc        = q.extExc;
  assign supervisionState = q.sr;
  assign supervisorMode   = q.sr[`CPUST_SR_SM];
  assign dataCacheEn      = q.sr[`CPUST_SR_DCE];
  assign instrCacheEn     = q.sr[`CPUST_SR_ICE];
  assign dataMmuEn        = q.sr[`CPUST_SR_DME];
  assign instrMmuEn       = q.sr[`CPUST_SR_IME];
  assign littleEndian     = q.sr[`CPUST_SR_LEE];
  assign branchFlag       = q.sr[`CPUST_SR_F];
  assign carryFlag        = q.sr[`CPUST_SR_CY];
  // high base is a pure top-nibble pattern, so the flop bit is fanned out with no mux
  assign vectorBase       = {{4{q.sr[`CPUST_SR_EPH]}}, 28'h000_0000};
  assign contextIndex     = q.sr[`CPUST_SR_CID];
  assign fpTrapEn         = q.fp_control_status[`CPUST_FP_FP_TRAP_ENABLE];
  assign fpRoundSel       = cpust_pkg::cpust_round_t'(q.fp_control_status[`CPUST_FP_RM]);
  assign fpControlStatus  = q.fp_control_status;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence excPlainS;
    exc.take && !q.sr[`CPUST_SR_CE];
  endsequence

  sequence excSwitchS;
    exc.take && q.sr[`CPUST_SR_CE];
  endsequence

  sequence userMoveS;
    (spr.we || spr.re) && !q.sr[`CPUST_SR_SM] && spr.addr == `CPUST_IDX_SR;
  endsequence

  fixed_one_a: assert property (q.sr[`CPUST_SR_FO])
    else $error("fixed one bit cleared");

  zero_reg_a: assert property (rdAddrA == 5'h00 |=> rdDataA == 32'h0000_0000)
    else $error("register zero read nonzero");

  user_sr_deny_a: assert property (userMoveS |=> sprErr && sprRdata == 32'h0000_0000)
    else $error("user move to supervision state not refused");

  exc_pc_save_a: assert property (excPlainS |=> q.epc[0] == $past(exc.pc))
    else $error("return pc not saved");

  exc_ea_save_a: assert property (excPlainS |=> q.exception_fault_address[0] == $past(exc.ea))
    else $error("fault address not saved");

  exc_sr_copy_a: assert property (excPlainS |=> q.exception_saved_state[0] == $past(q.sr))
    else $error("supervision state not copied");

  cid_step_a: assert property (excSwitchS |=>
      contextIndex == $past(contextIndex) + 4'h1)
    else $error("context index did not step");

  range_trap_a: assert property (alu.aluWe && alu.overflow && q.sr[`CPUST_SR_OVE] |=>
      rangeExc ##1 !rangeExc || alu.aluWe)
    else $error("range exception missing");

  no_range_a: assert property (!(alu.aluWe && q.sr[`CPUST_SR_OVE]) |=> !rangeExc)
    else $error("range exception without trap enable");

  tick_gate_a: assert property (tickReq && !q.sr[`CPUST_SR_TEE] |=> !tickExc)
    else $error("tick recognized while disabled");

  fp_flag_set_a: assert property (fpDone |=>
      (fpControlStatus[11:3] & $past(fpFlags)) == $past(fpFlags))
    else $error("fp status flag lost");

  reset_state_a: assert property (@(posedge clk_sys) srst |=> q.sr == `CPUST_SR_RESET)
    else $error("wrong supervision state after reset");

  dsx_track_a: assert property (exc.take |=> q.sr[`CPUST_SR_DSX] == $past(exc.delaySlot))
    else $error("delay slot bit wrong");

endmodule

// File: shared/cpust_cfg.svh
// constants for the processor architectural state block
`ifndef CPUST_CFG_SVH
`define CPUST_CFG_SVH

// special-register indices
`define CPUST_IDX_SR     16'h0011
`define CPUST_IDX_FP_CONTROL_STATUS  16'h0014
`define CPUST_IDX_EPC    16'h0020
`define CPUST_IDX_EXCEPTION_FAULT_ADDRESS   16'h0030
`define CPUST_IDX_ESR    16'h0040
`define CPUST_IDX_GPR    16'h0400

// supervision state fields
`define CPUST_SR_SM      0
`define CPUST_SR_TEE     1
`define CPUST_SR_IEE     2
`define CPUST_SR_DCE     3
`define CPUST_SR_ICE     4
`define CPUST_SR_DME     5
`define CPUST_SR_IME     6
`define CPUST_SR_LEE     7
`define CPUST_SR_CE      8
`define CPUST_SR_F       9
`define CPUST_SR_CY      10
`define CPUST_SR_OV      11
`define CPUST_SR_OVE     12
`define CPUST_SR_DSX     13
`define CPUST_SR_EPH     14
`define CPUST_SR_FO      15
`define CPUST_SR_USER_SPR_READ_ENABLE   16
`define CPUST_SR_CID     31:28
`define CPUST_SR_RESET   32'h0000_8001
`define CPUST_SR_WMASK   32'hf001_ffff
`define CPUST_SR_ONE     32'h0000_8000

// fp control fields
`define CPUST_FP_FP_TRAP_ENABLE    0
`define CPUST_FP_RM      2:1
`define CPUST_FP_FLAGS   11:3
`define CPUST_FP_WMASK   32'h0000_0fff
`define CPUST_FP_RESET   32'h0000_0000

// vector base when high select is set
`define CPUST_VEC_HIGH   32'hf000_0000

`endif

// File: shared/cpust_pkg.sv
// types of the processor architectural state block
package cpust_pkg;

  // special-register move request
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [31:0] wdata;
  } cpust_spr_t;

  // exception entry event
  typedef struct packed {
    logic        take;
    logic        delaySlot;
    logic [31:0] pc;
    logic [31:0] ea;
  } cpust_exc_t;

  // arithmetic and compare flag update
  typedef struct packed {
    logic aluWe;
    logic carry;
    logic overflow;
    logic cmpWe;
    logic cmpFlag;
  } cpust_alu_t;

  // rounding modes
  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_ZERO    = 2'h1,
    RND_POS_INF = 2'h2,
    RND_NEG_INF = 2'h3
  } cpust_round_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0][31:0][31:0] general_register;
    logic [31:0]             sr;
    logic [15:0][31:0]       epc;
    logic [15:0][31:0]       exception_fault_address;
    logic [15:0][31:0]       exception_saved_state;
    logic [31:0]             fp_control_status;
    logic [31:0]             rdA;
    logic [31:0]             rdB;
    logic [31:0]             sprRdata;
    logic                    sprErr;
    logic                    rangeExc;
    logic                    tickExc;
    logic                    extExc;
  } cpust_state_t;

endpackage

// File: sim/cpust_pipe.sv
// pipeline stand-in that drives the state block's request ports
`timescale 1ns/1ps

module cpust_pipe (
  input wire logic clk_sys
);
  // request lines, idle at time zero except tick and extIrq, which start high
  cpust_pkg::cpust_spr_t spr    = '0;   // special-register move
  cpust_pkg::cpust_exc_t exc    = '0;   // exception entry
  cpust_pkg::cpust_alu_t alu    = '0;   // flag updates
  logic [4:0]            rdA    = '0;   // operand address, both ports
  logic                  gprWe  = 1'b0; // register write strobe
  logic [4:0]            wAddr  = '0;   // register write address
  logic [31:0]           wData  = '0;   // register write data
  logic                  fpDone = 1'b0; // fp completion
  logic [8:0]            fpFlg  = '0;   // fp status flags
  logic                  tick   = 1'b1; // tick request level
  logic                  extIrq = 1'b1; // external request level

  // one move pulse; lines flip once released so stale values never look valid
  task automatic move(input logic w, r, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    spr <= {w, r, a, d};
    @(posedge clk_sys);
    spr <= {2'b00, ~a, ~d};
  endtask

  // one general register write
  task automatic gw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    gprWe <= 1'b1;
    wAddr <= a;
    wData <= d;
    @(posedge clk_sys);
    gprWe <= 1'b0;
    wData <= ~d;
  endtask

  // operand read, data lands at the following edge
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    rdA <= a;
    @(posedge clk_sys);
  endtask

  // exception entry pulse
  task automatic ex(input logic ds, input logic [31:0] pc, ea);
    @(posedge clk_sys);
    exc <= {1'b1, ds, pc, ea};
    @(posedge clk_sys);
    exc <= {2'b00, ~pc, ~ea};
  endtask

  // flag update pulse from the alu or a compare
  task automatic fl(input cpust_pkg::cpust_alu_t v);
    @(posedge clk_sys);
    alu <= v;
    @(posedge clk_sys);
    alu <= '0;
  endtask

  // fp completion pulse with its flags
  task automatic fp(input logic [8:0] f);
    @(posedge clk_sys);
    fpDone <= 1'b1;
    fpFlg  <= f;
    @(posedge clk_sys);
    fpDone <= 1'b0;
    fpFlg  <= ~f;
  endtask
endmodule

// File: sim/tb_cpu_state_registers.sv
// self-checking bench for the processor state block
`timescale 1ns/1ps

module tb_cpu_state_registers;
  logic        clk_sys     = 1'b0;  // 40 MHz core clock
  logic        srst        = 1'b1;  // held for the first 12 edges
  int          miscompares = 0;     // mismatches seen
  int          checked     = 0;     // comparisons made
  integer      seed        = 96275; // fixed random seed
  logic [31:0] srM, fpM, d;         // reference state, fp control, scratch
  logic [31:0] gprM [32];           // reference set-0 registers
  logic [4:0]  regs [3] = '{5'd0, 5'd31, 5'd5}; // registers exercised
  logic [31:0] rdDataA, rdDataB, sprRdata, supervisionState, vectorBase, fpControlStatus;
  logic        sprErr, rangeExc, tickExc, extIrqExc, supervisorMode, dataCacheEn;
  logic        instrCacheEn, dataMmuEn, instrMmuEn, littleEndian, branchFlag, carryFlag;
  logic        fpTrapEn;
  logic [3:0]  contextIndex;
  cpust_pkg::cpust_round_t fpRoundSel;

  cpust_pipe u_cpust_pipe (.clk_sys);

  cpust_regs u_cpust_regs (
    .clk_sys, .srst, .rdAddrA(u_cpust_pipe.rdA), .rdAddrB(u_cpust_pipe.rdA),
    .gprWe(u_cpust_pipe.gprWe), .gprWaddr(u_cpust_pipe.wAddr), .gprWdata(u_cpust_pipe.wData),
    .spr(u_cpust_pipe.spr), .exc(u_cpust_pipe.exc), .alu(u_cpust_pipe.alu),
    .fpDone(u_cpust_pipe.fpDone), .fpFlags(u_cpust_pipe.fpFlg), .tickReq(u_cpust_pipe.tick),
    .extIrqReq(u_cpust_pipe.extIrq), .rdDataA, .rdDataB, .sprRdata, .sprErr, .rangeExc,
    .tickExc, .extIrqExc, .supervisionState, .supervisorMode, .dataCacheEn, .instrCacheEn,
    .dataMmuEn, .instrMmuEn, .littleEndian, .branchFlag, .carryFlag, .vectorBase,
    .contextIndex, .fpTrapEn, .fpRoundSel, .fpControlStatus
  );

  // free-running clock, 25 ns period
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // compare one value and count it
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // counts, verdict and end of run
  task automatic wrap_up();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // supervision state write; refused in user mode
  task automatic srW(input logic [31:0] v);
    u_cpust_pipe.move(1'b1, 1'b0, 16'h0011, v);
    if (srM[0]) srM = (v & 32'hf001ffff) | 32'h8000;
    #1;
    chk("sr", srM, supervisionState);
  endtask

  // special-register read with expected data or refusal
  task automatic rdS(input logic [15:0] a, input logic [31:0] e, input logic err);
    u_cpust_pipe.move(1'b0, 1'b1, a, $random(seed));
    #1;
    chk("spr data", err ? 32'h0 : e, sprRdata);
    chk("spr refused", {31'h0, err}, {31'h0, sprErr});
  endtask

  // exception entry, then read back the save slot it used
  task automatic trap(input logic ds);
    logic [31:0] pc, ea, old;
    logic [3:0]  k, slot;
    pc = $random(seed);
    ea = $random(seed);
    old = srM;
    k = old[8] ? old[31:28] + 4'h1 : old[31:28];
    slot = old[8] ? k : 4'h0;
    u_cpust_pipe.ex(ds, pc, ea);
    srM = {k, old[27:14], ds, old[12:3], 2'b00, 1'b1};
    #1;
    chk("sr entry", srM, supervisionState);
    rdS(16'h0020 + {12'h0, slot}, pc, 1'b0);
    rdS(16'h0030 + {12'h0, slot}, ea, 1'b0);
    rdS(16'h0040 + {12'h0, slot}, old, 1'b0);
  endtask

  // cuts a hang short
  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    srM = 32'h8001;
    fpM = 32'h0;
    foreach (gprM[i]) gprM[i] = 32'h0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("sr reset", srM, supervisionState);
    chk("fp reset", fpM, fpControlStatus);
    $display("test reset done");
    // random writes, kept in supervisor mode, fixed-one bit written as zero
    repeat (6) begin
      srW(($random(seed) | 32'h1) & 32'hffff7fff);
      chk("vector", srM[14] ? 32'hf0000000 : 32'h0, vectorBase);
      chk("fields", {22'h0, srM[31:28], srM[7:3], srM[0]}, {22'h0, contextIndex, littleEndian,
          instrMmuEn, dataMmuEn, instrCacheEn, dataCacheEn, supervisorMode});
      rdS(16'h0011, srM, 1'b0);
      chk("irq", {30'h0, srM[2:1]}, {30'h0, extIrqExc, tickExc});
    end
    $display("test supervision fields done");
    // flag updates with and without the range trap
    for (int i = 0; i < 2; i++) begin
      srW(i ? 32'h1001 : 32'h1);
      u_cpust_pipe.fl({1'b1, i[0], 1'b1, 1'b1, i[0]});
      srM[11:9] = {1'b1, i[0], i[0]};
      #1;
      chk("range", {31'h0, i[0]}, {31'h0, rangeExc});
      chk("flags", srM, supervisionState);
      chk("flag pins", {30'h0, i[0], i[0]}, {30'h0, carryFlag, branchFlag});
    end
    $display("test flags done");
    // register zero, top register and a middle one
    foreach (regs[k]) begin
      d = $random(seed);
      u_cpust_pipe.gw(regs[k], d);
      gprM[regs[k]] = (regs[k] != 5'd0) ? d : 32'h0;
      u_cpust_pipe.rd(regs[k]);
      #1;
      chk("gpr a", gprM[regs[k]], rdDataA);
      chk("gpr b", gprM[regs[k]], rdDataB);
    end
    $display("test general registers done");
    // every rounding mode, then sticky flags and their clearing
    for (int m = 0; m < 4; m++) begin
      fpM = {29'h0, m[1:0], 1'b1};
      u_cpust_pipe.move(1'b1, 1'b0, 16'h0014, fpM);
      #1;
      chk("round", {30'h0, m[1:0]}, {30'h0, fpRoundSel});
      chk("trap en", 32'h1, {31'h0, fpTrapEn});
    end
    repeat (2) begin
      d = $random(seed);
      u_cpust_pipe.fp(d[8:0]);
      fpM[11:3] = fpM[11:3] | d[8:0];
      #1;
      chk("fp flags", fpM, fpControlStatus);
    end
    fpM[11:3] = 9'h0;
    u_cpust_pipe.move(1'b1, 1'b0, 16'h0014, fpM);
    #1;
    chk("fp clear", fpM, fpControlStatus);
    $display("test fp control done");
    // exception with auto-switch on moves to shadow set 1
    srW(32'h0000_0107);
    trap(1'b1);
    d = $random(seed);
    u_cpust_pipe.gw(5'd5, d);
    u_cpust_pipe.rd(5'd5);
    #1;
    chk("shadow", d, rdDataA);
    rdS(16'h0405, gprM[5], 1'b0);
    rdS(16'h0425, d, 1'b0);
    $display("test exception done");
    // user mode with and without user read permission
    for (int u = 0; u < 2; u++) begin
      srW({15'h0, u[0], 16'h0});
      chk("mode", 32'h0, {31'h0, supervisorMode});
      rdS(16'h0011, 32'h0, 1'b1);
      rdS(16'h0014, fpM, !u[0]);
      u_cpust_pipe.move(1'b1, 1'b0, 16'h0014, 32'h6);
      #1;
      chk("fp user write", fpM, fpControlStatus);
      trap(1'b0);
    end
    $display("test user mode done");
    wrap_up();
  end
endmodule
